// ---- src/sebo_byte_if.sv ----
// Interface carrying a valid/ready byte stream between the unit's own modules
`timescale 1ns/10ps
interface sebo_byte_if #(parameter int W = 8);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : sebo_byte_if

// ---- src/sebo_exec.sv ----
// Execution unit for pair push/pop, immediate pair loads, bank swaps and block copy/compare
`timescale 1ns/10ps
module sebo_exec #(
	parameter int FIFO_DEPTH = sebo_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Instruction byte stream
	input wire logic ibyte_valid,
	output logic ibyte_ready,
	input wire logic [sebo_pkg::DATA_W-1:0] ibyte_data,
	// Memory byte port
	output logic mem_req,
	output logic mem_we,
	output logic [sebo_pkg::ADDR_W-1:0] mem_addr,
	output logic [sebo_pkg::DATA_W-1:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic [sebo_pkg::DATA_W-1:0] mem_rdata,
	// Status
	output logic busy,
	output logic instr_done,
	output logic instr_bad,
	// Architectural state
	output logic [15:0] accumulator_flags_pair,
	output logic [15:0] byte_count_pair,
	output logic [15:0] target_pointer_pair,
	output logic [15:0] source_pointer_pair,
	output logic [15:0] stack_pointer
);
	import sebo_pkg::*;

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic rst_s1_q;
	logic rst_s2_q;
	// Assert is immediate, release waits two clocks so no flop leaves reset mid-edge
	wire rst_n = rst_s2_q;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end

	// ----------------------------------------
	// Instruction byte buffer
	// ----------------------------------------
	// The decoder only drains while fetching, so a long block
	// instruction backs the stream up into the source.
	sebo_byte_if #(.W(DATA_W)) fq ();

	sebo_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(ibyte_valid),
		.in_ready(ibyte_ready),
		.in_data(ibyte_data),
		.out(fq.src)
	);

	// ----------------------------------------
	// State
	// ----------------------------------------
	sebo_state_e st_q;
	sebo_state_e st_d;
	sebo_regs_s r_q;
	sebo_regs_s r_d;
	logic [7:0] op_q;
	logic [7:0] op_d;
	logic [7:0] lo_q;
	logic [7:0] lo_d;
	logic [7:0] byte_q;
	logic [7:0] byte_d;
	logic done_q;
	logic done_d;
	logic bad_q;
	logic bad_d;
	logic fetch_ready;
	logic [15:0] addr_q;
	logic [15:0] addr_d;
	logic [7:0] wdata_q;
	logic [7:0] wdata_d;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire [7:0] fb = fq.data;
	wire is_push = ((fb & OP_PAIR_MASK) == OP_PUSH_BASE);
	wire is_pop = ((fb & OP_PAIR_MASK) == OP_POP_BASE);
	wire is_ldimm = ((fb & OP_PAIR_MASK) == OP_LDIMM_BASE);
	wire is_blk = ((fb & OP_BLK_MASK) == OP_BLK_BASE);
	wire [1:0] sel = op_q[PAIR_SEL_LSB +: 2];
	// Block opcodes differ only in the compare, direction and repeat bits
	wire blk_cmp = op_q[BLK_CMP_BIT];
	wire blk_up = !op_q[BLK_DOWN_BIT];
	wire blk_rep = op_q[BLK_REP_BIT];

	// Pointer steps, all wrapping on 16 bits
	wire [15:0] sp_dec = sebo_step16(r_q.sp, 1'b0); // [RULE14]
	wire [15:0] sp_inc = sebo_step16(r_q.sp, 1'b1); // [RULE14]
	wire [15:0] hl_next = sebo_step16(r_q.hl, blk_up); // [RULE9] [RULE13] [RULE14]
	wire [15:0] de_next = sebo_step16(r_q.de, blk_up); // [RULE9] [RULE14]
	wire [15:0] bc_next = sebo_step16(r_q.bc, 1'b0); // [RULE14]
	wire bc_left = (bc_next != PAIR_RST);
	wire cmp_hit = (r_q.af[15:8] == mem_rdata);

	// ----------------------------------------
	// Memory port
	// ----------------------------------------
	// Request and direction stay combinational from the state flop, while
	// address and write byte are worked out from the next state and held
	// in flops: the memory sees clean levels that stand until the ack.
	wire in_push = (st_q == ST_PUSH_HI) || (st_q == ST_PUSH_LO);
	wire in_pop = (st_q == ST_POP_LO) || (st_q == ST_POP_HI);
	wire in_blk = (st_q == ST_BLK_RD) || (st_q == ST_BLK_WR);
	wire [1:0] sel_d = op_d[PAIR_SEL_LSB +: 2];
	wire in_push_d = (st_d == ST_PUSH_HI) || (st_d == ST_PUSH_LO);
	wire in_pop_d = (st_d == ST_POP_LO) || (st_d == ST_POP_HI);
	wire in_blk_d = (st_d == ST_BLK_RD) || (st_d == ST_BLK_WR);
	// Pair named by the opcode; the top code is the accumulator-flags pair for stack ops
	wire [15:0] push_pair_d = (sel_d == SEL_BC) ? r_d.bc :
		(sel_d == SEL_DE) ? r_d.de :
		(sel_d == SEL_HL) ? r_d.hl : r_d.af;

	assign mem_req = in_push || in_pop || in_blk;
	assign mem_we = in_push || (st_q == ST_BLK_WR);
	// Full 16-bit addresses, overlap left to software
	assign addr_d = in_push_d ? sebo_step16(r_d.sp, 1'b0) : // [RULE1] [RULE2]
		in_pop_d ? r_d.sp : // [RULE3]
		(st_d == ST_BLK_WR) ? r_d.de : // [RULE10]
		in_blk_d ? r_d.hl : PAIR_RST;
	assign wdata_d = (st_d == ST_PUSH_HI) ? push_pair_d[15:8] : // [RULE1] [RULE2]
		(st_d == ST_PUSH_LO) ? push_pair_d[7:0] :
		(st_d == ST_BLK_WR) ? byte_d : BYTE_RST;
	assign mem_addr = addr_q;
	assign mem_wdata = wdata_q;

	// Reset parks the bus at zero, the same as an idle fetch
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_q <= PAIR_RST;
			wdata_q <= BYTE_RST;
		end else begin
			addr_q <= addr_d;
			wdata_q <= wdata_d;
		end
	end

	// ----------------------------------------
	// Status outputs
	// ----------------------------------------
	assign fq.ready = fetch_ready;
	assign busy = (st_q != ST_FETCH);
	assign instr_done = done_q;
	assign instr_bad = bad_q;
	assign accumulator_flags_pair = r_q.af;
	assign byte_count_pair = r_q.bc;
	assign target_pointer_pair = r_q.de;
	assign source_pointer_pair = r_q.hl;
	assign stack_pointer = r_q.sp;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	// One step per clock; memory states wait on the ack with no time limit,
	// so a memory that never answers stalls the unit here.
	always_comb begin
		st_d = st_q;
		r_d = r_q;
		op_d = op_q;
		lo_d = lo_q;
		byte_d = byte_q;
		done_d = 1'b0;
		bad_d = 1'b0;
		fetch_ready = 1'b0;
		case (st_q)
			ST_FETCH: begin
				fetch_ready = 1'b1;
				if (fq.valid) begin
					op_d = fb;
					if (fb == OP_PREFIX_ED) begin
						st_d = ST_FETCH_ED;
					end else if (fb == OP_SWAP_AF) begin
						r_d.af = r_q.af_alt; // [RULE5]
						r_d.af_alt = r_q.af; // [RULE5]
						done_d = 1'b1;
					end else if (fb == OP_SWAP_SET) begin
						r_d.bc = r_q.bc_alt; // [RULE6]
						r_d.de = r_q.de_alt; // [RULE6]
						r_d.hl = r_q.hl_alt; // [RULE6]
						r_d.bc_alt = r_q.bc; // [RULE6]
						r_d.de_alt = r_q.de; // [RULE6]
						r_d.hl_alt = r_q.hl; // [RULE6]
						done_d = 1'b1;
					end else if (is_push) begin
						st_d = ST_PUSH_HI;
					end else if (is_pop) begin
						st_d = ST_POP_LO;
					end else if (is_ldimm) begin
						st_d = ST_IMM_LO;
					end else begin
						bad_d = 1'b1;
					end
				end
			end
			ST_FETCH_ED: begin
				fetch_ready = 1'b1;
				if (fq.valid) begin
					op_d = fb;
					if (is_blk) begin
						st_d = ST_BLK_RD;
					end else begin
						bad_d = 1'b1;
						st_d = ST_FETCH;
					end
				end
			end
			ST_IMM_LO: begin
				fetch_ready = 1'b1;
				if (fq.valid) begin
					lo_d = fb; // [RULE4]
					st_d = ST_IMM_HI;
				end
			end
			ST_IMM_HI: begin
				fetch_ready = 1'b1;
				if (fq.valid) begin
					case (sel)
						SEL_BC: r_d.bc = {fb, lo_q}; // [RULE4]
						SEL_DE: r_d.de = {fb, lo_q}; // [RULE4]
						SEL_HL: r_d.hl = {fb, lo_q}; // [RULE4]
						default: r_d.sp = {fb, lo_q}; // [RULE4]
					endcase
					done_d = 1'b1;
					st_d = ST_FETCH;
				end
			end
			ST_PUSH_HI: begin
				if (mem_ack) begin
					r_d.sp = sp_dec; // [RULE1] [RULE2]
					st_d = ST_PUSH_LO;
				end
			end
			ST_PUSH_LO: begin
				if (mem_ack) begin
					r_d.sp = sp_dec; // [RULE1] [RULE2]
					done_d = 1'b1;
					st_d = ST_FETCH;
				end
			end
			ST_POP_LO: begin
				if (mem_ack) begin
					lo_d = mem_rdata; // [RULE3]
					r_d.sp = sp_inc; // [RULE3]
					st_d = ST_POP_HI;
				end
			end
			ST_POP_HI: begin
				if (mem_ack) begin
					case (sel)
						SEL_BC: r_d.bc = {mem_rdata, lo_q}; // [RULE3]
						SEL_DE: r_d.de = {mem_rdata, lo_q}; // [RULE3]
						SEL_HL: r_d.hl = {mem_rdata, lo_q}; // [RULE3]
						default: r_d.af = {mem_rdata, lo_q}; // [RULE3]
					endcase
					r_d.sp = sp_inc; // [RULE3]
					done_d = 1'b1;
					st_d = ST_FETCH;
				end
			end
			ST_BLK_RD: begin
				if (mem_ack) begin
					if (blk_cmp) begin
						// Accumulator is only compared, never changed
						r_d.af[FLAG_Z_BIT] = cmp_hit; // [RULE11]
						r_d.af[FLAG_N_BIT] = 1'b1;
						r_d.af[FLAG_PV_BIT] = bc_left;
						r_d.hl = hl_next; // [RULE11] [RULE13]
						r_d.bc = bc_next; // [RULE11]
						if (blk_rep && bc_left && !cmp_hit) begin
							st_d = ST_BLK_RD; // [RULE12]
						end else begin
							done_d = 1'b1;
							st_d = ST_FETCH;
						end
					end else begin
						byte_d = mem_rdata; // [RULE7]
						st_d = ST_BLK_WR;
					end
				end
			end
			ST_BLK_WR: begin
				if (mem_ack) begin
					r_d.hl = hl_next; // [RULE7] [RULE9]
					r_d.de = de_next; // [RULE7] [RULE9]
					r_d.bc = bc_next; // [RULE7]
					r_d.af[FLAG_H_BIT] = 1'b0;
					r_d.af[FLAG_N_BIT] = 1'b0;
					r_d.af[FLAG_PV_BIT] = bc_left;
					if (blk_rep && bc_left) begin
						st_d = ST_BLK_RD; // [RULE8] [RULE10]
					end else begin
						done_d = 1'b1;
						st_d = ST_FETCH;
					end
				end
			end
			default: begin
				st_d = ST_FETCH;
			end
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= ST_FETCH;
			r_q <= '0;
			op_q <= BYTE_RST;
			lo_q <= BYTE_RST;
			byte_q <= BYTE_RST;
			done_q <= 1'b0;
			bad_q <= 1'b0;
		end else begin
			st_q <= st_d;
			r_q <= r_d;
			op_q <= op_d;
			lo_q <= lo_d;
			byte_q <= byte_d;
			done_q <= done_d;
			bad_q <= bad_d;
		end
	end

endmodule : sebo_exec

// ---- src/sebo_fifo.sv ----
// Small valid/ready FIFO holding instruction bytes ahead of the decoder
`timescale 1ns/10ps
module sebo_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Drain side
	sebo_byte_if.src out
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	logic [W-1:0] mem_q [DEPTH];
	logic [PW-1:0] wr_q;
	logic [PW-1:0] rd_q;
	logic [CW-1:0] cnt_q;
	wire push = in_valid && in_ready;
	wire pop = out.valid && out.ready;

	assign in_ready = (cnt_q != FULL);
	assign out.valid = (cnt_q != '0);
	assign out.data = mem_q[rd_q];

	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	// Pointers wrap by compare so depth need not be a power of two
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) wr_q <= (wr_q == LAST) ? '0 : wr_q + 1'b1;
			if (pop) rd_q <= (rd_q == LAST) ? '0 : rd_q + 1'b1;
			if (push && !pop) cnt_q <= cnt_q + 1'b1;
			else if (pop && !push) cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule : sebo_fifo

// ---- src/sebo_pkg.sv ----
// Package with opcodes, flag layout, reset values and types for the stack, swap and block unit
// Functional notes
// RULE1 - F5 push: dec, write A, dec, write flags
// RULE2 - Pair push writes high byte then low
// RULE3 - Pair pop reads low then high, incrementing
// RULE4 - Sixteen-bit operand bytes arrive low first
// RULE5 - Opcode 08 swaps accumulator-flags with alternate
// RULE6 - Opcode D9 swaps all three general pairs
// RULE7 - Copy up: move byte, inc pointers, dec count
// RULE8 - Repeating copy up runs until count zero
// RULE9 - Copy down decrements both pointers instead
// RULE10 - Full 16-bit pointers, no overlap check
// RULE11 - Compare up: flag result, inc source, dec count
// RULE12 - Repeating compare stops on match or zero
// RULE13 - Compare down decrements the source pointer
// RULE14 - All pointer arithmetic wraps modulo 65536
package sebo_pkg;

	// ----------------------------------------
	// Widths and sizes
	// ----------------------------------------
	localparam int DATA_W = 8;
	localparam int ADDR_W = 16;
	localparam int FIFO_DEPTH = 4;

	// ----------------------------------------
	// Opcodes and decode masks
	// ----------------------------------------
	localparam logic [7:0] OP_PREFIX_ED = 8'hED;
	localparam logic [7:0] OP_SWAP_AF = 8'h08;
	localparam logic [7:0] OP_SWAP_SET = 8'hD9;
	localparam logic [7:0] OP_PAIR_MASK = 8'hCF;
	localparam logic [7:0] OP_PUSH_BASE = 8'hC5;
	localparam logic [7:0] OP_POP_BASE = 8'hC1;
	localparam logic [7:0] OP_LDIMM_BASE = 8'h01;
	localparam logic [7:0] OP_BLK_MASK = 8'hE6;
	localparam logic [7:0] OP_BLK_BASE = 8'hA0;
	localparam int BLK_CMP_BIT = 0;
	localparam int BLK_DOWN_BIT = 3;
	localparam int BLK_REP_BIT = 4;
	localparam int PAIR_SEL_LSB = 4;
	localparam logic [1:0] SEL_BC = 2'h0;
	localparam logic [1:0] SEL_DE = 2'h1;
	localparam logic [1:0] SEL_HL = 2'h2;
	localparam logic [1:0] SEL_TOP = 2'h3;

	// ----------------------------------------
	// Flag bit positions and reset values
	// ----------------------------------------
	localparam int FLAG_Z_BIT = 6;
	localparam int FLAG_H_BIT = 4;
	localparam int FLAG_PV_BIT = 2;
	localparam int FLAG_N_BIT = 1;
	localparam logic [15:0] PAIR_RST = 16'h0000;
	localparam logic [7:0] BYTE_RST = 8'h00;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [3:0] {
		ST_FETCH = 4'b0000,
		ST_FETCH_ED = 4'b0001,
		ST_IMM_LO = 4'b0010,
		ST_IMM_HI = 4'b0011,
		ST_PUSH_HI = 4'b0100,
		ST_PUSH_LO = 4'b0101,
		ST_POP_LO = 4'b0110,
		ST_POP_HI = 4'b0111,
		ST_BLK_RD = 4'b1000,
		ST_BLK_WR = 4'b1001
	} sebo_state_e;

	typedef struct packed {
		logic [15:0] af;
		logic [15:0] bc;
		logic [15:0] de;
		logic [15:0] hl;
		logic [15:0] af_alt;
		logic [15:0] bc_alt;
		logic [15:0] de_alt;
		logic [15:0] hl_alt;
		logic [15:0] sp;
	} sebo_regs_s;

	// Step a pointer by one either way; carry out is simply dropped
	function automatic logic [15:0] sebo_step16(input logic [15:0] v, input logic up);
		logic [16:0] s;
		s = up ? ({1'b0, v} + 17'h00001) : ({1'b0, v} - 17'h00001);
		return s[15:0];
	endfunction : sebo_step16

endpackage : sebo_pkg

// ---- tb/sebo_exec_checker.sv ----
// Concurrent assertions on the ports of the stack, swap and block execution unit
`timescale 1ns/10ps
module sebo_exec_checker #(
	parameter int FIFO_DEPTH = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Memory port
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic [7:0] mem_rdata,
	// Status and state
	input wire logic busy,
	input wire logic instr_done,
	input wire logic instr_bad,
	input wire logic [15:0] byte_count_pair,
	input wire logic [15:0] target_pointer_pair,
	input wire logic [15:0] source_pointer_pair
);
	logic [7:0] rd_q;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// Last read byte, so a copy write can be matched against what was fetched
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) rd_q <= 8'h00;
		else if (mem_req && !mem_we && mem_ack) rd_q <= mem_rdata;
	end
	sequence s_read_ack;
		mem_req && !mem_we && mem_ack;
	endsequence
	sequence s_count_step;
		busy && byte_count_pair == $past(byte_count_pair) - 16'h0001;
	endsequence
	a_req_held: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we)
		&& $stable(mem_wdata)) else $error("memory request changed before ack");
	a_idle_no_req: assert property (!busy |-> !mem_req) else $error("memory access while idle");
	a_idle_bus_zero: assert property (!mem_req |-> mem_addr == 16'h0000 && mem_wdata == 8'h00)
		else $error("memory bus not parked");
	a_done_in_fetch: assert property (instr_done |-> !busy && !mem_req)
		else $error("done shown outside fetch");
	a_bad_not_done: assert property (instr_bad |-> !instr_done) else $error("bad and done together");
	a_count_moves_src: assert property (s_count_step |-> 16'(source_pointer_pair - $past(source_pointer_pair))
		inside {16'h0001, 16'hFFFF}) else $error("source pointer not stepped with count");
	a_dst_follows_src: assert property (s_count_step ##0 target_pointer_pair != $past(target_pointer_pair) |->
		16'(target_pointer_pair - $past(target_pointer_pair)) == 16'(source_pointer_pair - $past(source_pointer_pair)))
		else $error("target pointer stepped the wrong way");
	a_copy_writes_read: assert property (s_read_ack ##1 (mem_req && mem_we) |-> mem_wdata == rd_q
		&& mem_addr == target_pointer_pair) else $error("copy write differs from read");
endmodule : sebo_exec_checker

bind sebo_exec sebo_exec_checker #(.FIFO_DEPTH(FIFO_DEPTH)) i_chk (.clk(clk), .nrst(nrst), .mem_req(mem_req),
	.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
	.busy(busy), .instr_done(instr_done), .instr_bad(instr_bad), .byte_count_pair(byte_count_pair),
	.target_pointer_pair(target_pointer_pair), .source_pointer_pair(source_pointer_pair));

// ---- tb/sebo_mem_model.sv ----
// Behavioural byte memory on the far side of the unit's memory port
`timescale 1ns/10ps
module sebo_mem_model (
	// Clock and latency select
	input wire logic clk,
	input wire logic slow,
	// Memory port
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	output logic mem_ack,
	output logic [7:0] mem_rdata
);
	logic [7:0] mem [0:65535];
	logic [1:0] wait_q;
	initial begin
		mem_ack = 1'h0;
		mem_rdata = 8'h00;
		wait_q = 2'h0;
	end
	// Read data toggles outside ack so a late sample cannot pass by luck
	always @(posedge clk) begin
		mem_ack <= 1'h0;
		mem_rdata <= ~mem_rdata;
		if (mem_req && !mem_ack) begin
			if (wait_q >= (slow ? 2'h2 : 2'h0)) begin
				mem_ack <= 1'h1;
				wait_q <= 2'h0;
				if (mem_we) mem[mem_addr] <= mem_wdata;
				else mem_rdata <= mem[mem_addr];
			end else wait_q <= wait_q + 2'h1;
		end
	end
endmodule : sebo_mem_model

// ---- tb/testbench.sv ----
// Self-checking testbench for the stack, swap and block execution unit
`timescale 1ns/10ps
module testbench;
	import sebo_pkg::*;
	logic clk, nrst, ibyte_valid, ibyte_ready, mem_req, mem_we, mem_ack, slow, busy, instr_done, instr_bad;
	logic [7:0] ibyte_data, mem_wdata, mem_rdata;
	logic [15:0] mem_addr, af, bc, de, hl, sp;
	int mismatches, n_tests, n_end, n_bad;
	sebo_exec i_dut (.clk(clk), .nrst(nrst), .ibyte_valid(ibyte_valid), .ibyte_ready(ibyte_ready),
		.ibyte_data(ibyte_data), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata), .busy(busy), .instr_done(instr_done), .instr_bad(instr_bad),
		.accumulator_flags_pair(af), .byte_count_pair(bc), .target_pointer_pair(de),
		.source_pointer_pair(hl), .stack_pointer(sp));
	sebo_mem_model i_mem (.clk(clk), .slow(slow), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
	always @(posedge clk) begin
		if (instr_done === 1'h1 || instr_bad === 1'h1) n_end <= n_end + 1;
		if (instr_bad === 1'h1) n_bad <= n_bad + 1;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Streams bytes in, then waits for n instructions to finish
	task automatic run(input logic [7:0] b[$], input int n);
		int n0;
		n0 = n_end;
		@(posedge clk);
		foreach (b[i]) begin
			ibyte_valid <= 1'h1;
			ibyte_data <= b[i];
			@(negedge clk);
			while (ibyte_ready !== 1'h1) @(negedge clk);
			@(posedge clk);
		end
		ibyte_valid <= 1'h0;
		repeat (3000) if (n_end < n0 + n) @(posedge clk);
		@(negedge clk);
		chk(16'(n_end - n0), 16'(n));
	endtask : run
	task automatic t_stack();
		run({8'h31, 8'h01, 8'h00, 8'h01, 8'h34, 8'h12}, 2);
		chk(sp, 16'h0001);
		chk(bc, 16'h1234);
		run({8'hC5}, 1);
		chk({i_mem.mem[16'h0000], i_mem.mem[16'hFFFF]}, 16'h1234);
		chk(sp, 16'hFFFF);
		run({8'hD1}, 1);
		chk(de, 16'h1234);
		i_mem.mem[16'h0001] = 8'hC3;
		i_mem.mem[16'h0002] = 8'h5A;
		run({8'hF1}, 1);
		chk(af, 16'h5AC3);
		chk(sp, 16'h0003);
		run({8'h31, 8'h00, 8'h01, 8'hF5}, 2);
		chk({i_mem.mem[16'h00FF], i_mem.mem[16'h00FE]}, 16'h5AC3);
		chk(sp, 16'h00FE);
	endtask : t_stack
	task automatic t_swap();
		run({8'h08}, 1);
		chk(af, 16'h0000);
		run({8'h08, 8'h21, 8'hCD, 8'hAB, 8'hD9}, 3);
		chk(af, 16'h5AC3);
		chk(bc | de | hl, 16'h0000);
		run({8'hD9}, 1);
		chk(hl, 16'hABCD);
		chk(bc, 16'h1234);
	endtask : t_swap
	task automatic t_copy();
		logic [7:0] op[4] = '{8'hA0, 8'hB0, 8'hA8, 8'hB8};
		logic [7:0] lo;
		logic [15:0] n;
		logic dn;
		for (int k = 0; k < 4; k++) i_mem.mem[16'h2000 + k] = 8'h40 + k[7:0];
		for (int i = 0; i < 4; i++) begin
			dn = op[i][3];
			n = op[i][4] ? 16'h0003 : 16'h0001;
			lo = dn ? 8'h03 : 8'h00;
			slow <= op[i][4];
			for (int k = 0; k < 4; k++) i_mem.mem[16'h3000 + k] = 8'h00;
			run({8'h21, lo, 8'h20, 8'h11, lo, 8'h30, 8'h01, 8'h03, 8'h00, 8'hED, op[i]}, 4);
			for (int k = 0; k < 4; k++)
				chk(i_mem.mem[16'h3000 + k], (dn ? k > 3 - n : k < n) ? 8'h40 + k[7:0] : 8'h00);
			chk(hl, dn ? 16'h2003 - n : 16'h2000 + n);
			chk(de, dn ? 16'h3003 - n : 16'h3000 + n);
			chk(bc, 16'h0003 - n);
		end
		// Overlapping ranges smear the first byte forward
		run({8'h21, 8'h00, 8'h20, 8'h11, 8'h01, 8'h20, 8'h01, 8'h03, 8'h00, 8'hED, 8'hB0}, 4);
		chk(i_mem.mem[16'h2003], 8'h40);
	endtask : t_copy
	task automatic cmp1(input logic [7:0] op, input logic [15:0] h, c, he, ce, input logic z);
		slow <= 1'h0;
		run({8'h21, h[7:0], h[15:8], 8'h01, c[7:0], c[15:8], 8'hED, op}, 3);
		chk(hl, he);
		chk(bc, ce);
		chk(af[FLAG_Z_BIT], z);
		chk(af[15:8], 8'h5A);
	endtask : cmp1
	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end
	initial begin
		nrst = 1'h0;
		ibyte_valid = 1'h0;
		ibyte_data = 8'h00;
		slow = 1'h0;
		repeat (10) @(posedge clk);
		nrst <= 1'h1;
		repeat (2) @(posedge clk);
		t_stack();
		t_swap();
		t_copy();
		{i_mem.mem[16'h4000], i_mem.mem[16'h4001], i_mem.mem[16'h4002], i_mem.mem[16'h4003]} = 32'h11225A33;
		cmp1(8'hB1, 16'h4000, 16'h0004, 16'h4003, 16'h0001, 1'h1);
		cmp1(8'hA1, 16'h4000, 16'h0004, 16'h4001, 16'h0003, 1'h0);
		cmp1(8'hA9, 16'h4002, 16'h0004, 16'h4001, 16'h0003, 1'h1);
		cmp1(8'hB9, 16'h4001, 16'h0002, 16'h3FFF, 16'h0000, 1'h0);
		run({8'hED, 8'h00, 8'h00}, 2);
		chk(16'(n_bad), 16'h0002);
		stop_test();
	end
	// Watchdog: the whole sequence needs a few thousand cycles at most
	initial begin
		#(20000 * 100);
		mismatches++;
		stop_test();
	end
	task automatic stop_test();
		$display("mismatches %0d n_tests %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : stop_test
endmodule : testbench
